/* File: logic/asc_converter.sv */
// What this block does
// - Mode low: shift and sample every falling edge
// - Mode high: out on rising, eight per enable
// - Mode high: in on falling, eight per enable
// - Sender frames start, stop, eight/nine bits
// - Word length input picks nine or eight
// - Rate select builds sixteen-times sampling tick
// - Divider offers rates 300 to 38400
// - Select zero: reference clock is 16x tick
// - Reference at 4.096 MHz; dividers round down, no divided rate exact
// - Strip start/stop, push data to transmit FIFO
// - Transmit status when FIFO above two words
// - Receive FIFO words framed, sent at same rate
// - Receive status on overwrite, reset, lost sync
// - Eight selectable rates: one per nonzero code, plus the reference at zero
module asc_converter #(
	parameter int WORD_W = asc_pkg::DATA_W,
	parameter int DEPTH = asc_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic RST,
	// Asynchronous side and its rate
	input wire logic ASYNC_IN,
	output logic ASYNC_OUT,
	input wire logic RATE_REF_CLOCK,
	input wire logic RATE_SELECT_0,
	input wire logic RATE_SELECT_1,
	input wire logic RATE_SELECT_2,
	input wire logic WORD_LENGTH_SELECT,
	// Status
	output logic XMIT_FIFO_STATUS,
	output logic RECV_FIFO_STATUS,
	// Synchronous channel
	asc_sync_if.conv SYNC
);
	import asc_pkg::*;
	// Refuse sizes that the fixed-width counters cannot serve
	if (WORD_W != DATA_W || DEPTH != (1 << PTR_W)) begin : gen_bad_size
		$error("asc_converter: unsupported width or depth");
	end
	// =====================================================
	// Rate tick: edges of the reference, optionally divided
	logic ref_q_ff, nxt_ref_q;
	logic [DIV_W-1:0] div_ff, nxt_div;
	logic tick_ff, nxt_tick;
	logic [2:0] sel;
	logic [DIV_W-1:0] div_end;
	assign sel = {RATE_SELECT_2, RATE_SELECT_1, RATE_SELECT_0};
	// One divider value per nonzero code
	always_comb begin
		case (sel)
			3'h1: div_end = DIV_300;
			3'h2: div_end = DIV_600;
			3'h3: div_end = DIV_1200;
			3'h4: div_end = DIV_2400;
			3'h5: div_end = DIV_4800;
			3'h6: div_end = DIV_9600;
			3'h7: div_end = DIV_38400;
			default: div_end = '0;
		endcase
	end
	// Dividers round down; not exact even at the nominal reference
	always_comb begin
		nxt_ref_q = RATE_REF_CLOCK;
		nxt_div = div_ff;
		nxt_tick = 1'b0;
		if (RATE_REF_CLOCK && !ref_q_ff) begin
			if (sel == 3'h0) begin
				nxt_tick = 1'b1;
			end else if (div_ff >= div_end - 1'b1) begin
				nxt_div = '0;
				nxt_tick = 1'b1;
			end else begin
				nxt_div = div_ff + 1'b1;
			end
		end
	end
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			ref_q_ff <= 1'b0;
			div_ff <= '0;
			tick_ff <= 1'b0;
		end else begin
			ref_q_ff <= nxt_ref_q;
			div_ff <= nxt_div;
			tick_ff <= nxt_tick;
		end
	end
	// =====================================================
	// Asynchronous receiver into transmit FIFO
	typedef enum logic [2:0] {
		AR_IDLE = 3'b001,
		AR_DATA = 3'b010,
		AR_STOP = 3'b100
	} asc_arx_type;
	asc_arx_type ar_ff, nxt_ar;
	logic [3:0] ar_os_ff, nxt_ar_os;
	logic [3:0] ar_bit_ff, nxt_ar_bit;
	logic [WORD_W-1:0] ar_sh_ff, nxt_ar_sh;
	logic [3:0] nbits;
	logic tx_push;
	logic [WORD_W-1:0] tx_push_data;
	assign nbits = WORD_LENGTH_SELECT ? 4'h9 : 4'h8;
	always_comb begin
		nxt_ar = ar_ff;
		nxt_ar_os = ar_os_ff;
		nxt_ar_bit = ar_bit_ff;
		nxt_ar_sh = ar_sh_ff;
		tx_push = 1'b0;
		tx_push_data = ar_sh_ff;
		if (tick_ff) begin
			nxt_ar_os = ar_os_ff + 1'b1;
			case (ar_ff)
				AR_IDLE: begin
					if (ASYNC_IN) begin
						nxt_ar_os = '0;
					end else if (ar_os_ff == 4'(OS_MID)) begin
						nxt_ar_os = '0;
						nxt_ar_bit = '0;
						nxt_ar = AR_DATA;
					end
				end
				AR_DATA: begin
					if (ar_os_ff == 4'(OS_LAST)) begin
						nxt_ar_sh = {ASYNC_IN, ar_sh_ff[WORD_W-1:1]};
						nxt_ar_bit = ar_bit_ff + 1'b1;
						if (ar_bit_ff + 1'b1 == nbits)
							nxt_ar = AR_STOP;
					end
				end
				AR_STOP: begin
					if (ar_os_ff == 4'(OS_LAST)) begin
						nxt_ar_os = '0;
						nxt_ar = AR_IDLE;
						// Framing bits dropped; bad stop discards char
						tx_push = ASYNC_IN;
						tx_push_data = WORD_LENGTH_SELECT ? ar_sh_ff :
							{1'b0, ar_sh_ff[WORD_W-1:1]};
					end
				end
				default: nxt_ar = AR_IDLE;
			endcase
		end
	end
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			ar_ff <= AR_IDLE;
			ar_os_ff <= '0;
			ar_bit_ff <= '0;
			ar_sh_ff <= '0;
		end else begin
			ar_ff <= nxt_ar;
			ar_os_ff <= nxt_ar_os;
			ar_bit_ff <= nxt_ar_bit;
			ar_sh_ff <= nxt_ar_sh;
		end
	end
	// =====================================================
	// FIFOs: transmit drops new word when full, receive overwrites
	logic [WORD_W-1:0] txm [DEPTH];
	logic [WORD_W-1:0] rxm [DEPTH];
	logic [PTR_W:0] tx_wp_ff, nxt_tx_wp, tx_rp_ff, nxt_tx_rp;
	logic [PTR_W:0] rx_wp_ff, nxt_rx_wp, rx_rp_ff, nxt_rx_rp;
	logic [PTR_W:0] tx_cnt, rx_cnt;
	logic tx_pop, rx_push, rx_pop;
	logic [WORD_W-1:0] rx_push_data;
	logic rx_over;
	assign tx_cnt = tx_wp_ff - tx_rp_ff;
	assign rx_cnt = rx_wp_ff - rx_rp_ff;
	always_comb begin
		nxt_tx_wp = tx_wp_ff + ((tx_push && tx_cnt != (PTR_W+1)'(DEPTH)) ? 1'b1 : 1'b0);
		nxt_tx_rp = tx_rp_ff + (tx_pop ? 1'b1 : 1'b0);
		rx_over = rx_push && rx_cnt == (PTR_W+1)'(DEPTH) && !rx_pop;
		nxt_rx_wp = rx_wp_ff + (rx_push ? 1'b1 : 1'b0);
		nxt_rx_rp = rx_rp_ff + ((rx_pop || rx_over) ? 1'b1 : 1'b0);
	end
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			tx_wp_ff <= '0;
			tx_rp_ff <= '0;
			rx_wp_ff <= '0;
			rx_rp_ff <= '0;
		end else begin
			tx_wp_ff <= nxt_tx_wp;
			tx_rp_ff <= nxt_tx_rp;
			rx_wp_ff <= nxt_rx_wp;
			rx_rp_ff <= nxt_rx_rp;
		end
	end
	// Storage has no reset; pointers guard it
	always_ff @(posedge SYS_CLK) begin
		if (tx_push && tx_cnt != (PTR_W+1)'(DEPTH))
			txm[tx_wp_ff[PTR_W-1:0]] <= tx_push_data;
		if (rx_push)
			rxm[rx_wp_ff[PTR_W-1:0]] <= rx_push_data;
	end
	// =====================================================
	// Sync channel: edges of data clock, both directions
	logic dc_q_ff, nxt_dc_q;
	logic [WORD_W-1:0] so_sh_ff, nxt_so_sh;
	logic [3:0] so_left_ff, nxt_so_left;
	logic [CNT_W:0] so_burst_ff, nxt_so_burst;
	logic [WORD_W-1:0] si_sh_ff, nxt_si_sh;
	logic [3:0] si_cnt_ff, nxt_si_cnt;
	logic [CNT_W:0] si_burst_ff, nxt_si_burst;
	logic [7:0] flag_sh_ff, nxt_flag_sh;
	logic [SYNC_LOSS_W-1:0] loss_ff, nxt_loss;
	logic dco_ff, nxt_dco;
	logic rise, fall, out_edge, in_ok, out_ok, cont;
	assign cont = SYNC.clock_mode_select == MODE_CONT;
	assign rise = SYNC.sync_bit_clock && !dc_q_ff;
	assign fall = !SYNC.sync_bit_clock && dc_q_ff;
	assign out_edge = cont ? fall : rise;
	assign out_ok = SYNC.sync_out_enable && (cont || so_burst_ff < (CNT_W+1)'(8));
	assign in_ok = fall && SYNC.sync_in_enable &&
		(cont || si_burst_ff < (CNT_W+1)'(8));
	always_comb begin
		nxt_dc_q = SYNC.sync_bit_clock;
		nxt_so_sh = so_sh_ff;
		nxt_so_left = so_left_ff;
		nxt_so_burst = SYNC.sync_out_enable ? so_burst_ff : '0;
		nxt_si_burst = SYNC.sync_in_enable ? si_burst_ff : '0;
		nxt_si_sh = si_sh_ff;
		nxt_si_cnt = si_cnt_ff;
		nxt_flag_sh = flag_sh_ff;
		nxt_loss = loss_ff;
		nxt_dco = dco_ff;
		tx_pop = 1'b0;
		rx_push = 1'b0;
		rx_push_data = si_sh_ff;
		if (out_edge && out_ok) begin
			if (so_left_ff == '0 && tx_cnt != '0) begin
				// Start marker first, so the far end can find the word
				nxt_dco = 1'b0;
				nxt_so_sh = txm[tx_rp_ff[PTR_W-1:0]];
				nxt_so_left = nbits;
				tx_pop = 1'b1;
			end else if (so_left_ff != '0) begin
				nxt_dco = so_sh_ff[0];
				nxt_so_sh = so_sh_ff >> 1;
				nxt_so_left = so_left_ff - 1'b1;
			end else begin
				nxt_dco = LINE_IDLE;
			end
			nxt_so_burst = so_burst_ff + 1'b1;
		end
		if (in_ok) begin
			nxt_si_burst = si_burst_ff + 1'b1;
			nxt_flag_sh = {SYNC.sync_channel_in, flag_sh_ff[7:1]};
			if (si_cnt_ff == '0 && SYNC.sync_channel_in) begin
				// Idle marks between words
			end else if (si_cnt_ff == nbits) begin
				nxt_si_cnt = '0;
			end else begin
				nxt_si_sh = {SYNC.sync_channel_in, si_sh_ff[WORD_W-1:1]};
				nxt_si_cnt = si_cnt_ff + 1'b1;
				if (si_cnt_ff + 1'b1 == nbits + 1'b1) begin
					nxt_si_cnt = '0;
				end
			end
			// Start bit plus data collected: hand word over
			if (si_cnt_ff == nbits) begin
				rx_push = 1'b1;
				rx_push_data = WORD_LENGTH_SELECT ? {SYNC.sync_channel_in, si_sh_ff[WORD_W-1:1]}
					: {1'b0, SYNC.sync_channel_in, si_sh_ff[WORD_W-1:2]};
			end
			// Count bits since last flag word seen
			if ({SYNC.sync_channel_in, flag_sh_ff[7:1]} == SYNC_FLAG_WORD)
				nxt_loss = '0;
			else if (loss_ff != '1)
				nxt_loss = loss_ff + 1'b1;
		end
	end
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			dc_q_ff <= 1'b1; // Data clock rests high: no false edge
			so_sh_ff <= '0;
			so_left_ff <= '0;
			so_burst_ff <= '0;
			si_sh_ff <= '0;
			si_cnt_ff <= '0;
			si_burst_ff <= '0;
			flag_sh_ff <= '0;
			loss_ff <= '0;
			dco_ff <= LINE_IDLE;
		end else begin
			dc_q_ff <= nxt_dc_q;
			so_sh_ff <= nxt_so_sh;
			so_left_ff <= nxt_so_left;
			so_burst_ff <= nxt_so_burst;
			si_sh_ff <= nxt_si_sh;
			si_cnt_ff <= nxt_si_cnt;
			si_burst_ff <= nxt_si_burst;
			flag_sh_ff <= nxt_flag_sh;
			loss_ff <= nxt_loss;
			dco_ff <= nxt_dco;
		end
	end
	assign SYNC.sync_channel_out = dco_ff;
	// =====================================================
	// Async transmitter from receive FIFO, same tick
	logic [3:0] at_os_ff, nxt_at_os;
	logic [3:0] at_left_ff, nxt_at_left;
	logic [WORD_W+1:0] at_sh_ff, nxt_at_sh;
	logic out_ff, nxt_out;
	logic ovr_ff, nxt_ovr;
	logic xs_ff, nxt_xs, rs_ff, nxt_rs;
	always_comb begin
		nxt_at_os = at_os_ff;
		nxt_at_left = at_left_ff;
		nxt_at_sh = at_sh_ff;
		nxt_out = out_ff;
		rx_pop = 1'b0;
		if (tick_ff) begin
			nxt_at_os = at_os_ff + 1'b1;
			if (at_os_ff == 4'(OS_LAST)) begin
				if (at_left_ff != '0) begin
					nxt_out = at_sh_ff[0];
					nxt_at_sh = {1'b1, at_sh_ff[WORD_W+1:1]};
					nxt_at_left = at_left_ff - 1'b1;
				end else if (rx_cnt != '0) begin
					// Start bit, data, stop bit appended
					nxt_out = 1'b0;
					nxt_at_sh = WORD_LENGTH_SELECT ? {1'b1, 1'b1, rxm[rx_rp_ff[PTR_W-1:0]]}
						: {1'b1, 1'b1, 1'b1, rxm[rx_rp_ff[PTR_W-1:0]][WORD_W-2:0]};
					nxt_at_left = nbits + 1'b1;
					rx_pop = 1'b1;
				end else begin
					nxt_out = LINE_IDLE;
				end
			end
		end
		// Overwrite flag is sticky until the FIFO drains
		nxt_ovr = rx_over ? 1'b1 : (rx_cnt == '0 ? 1'b0 : ovr_ff);
		nxt_xs = tx_cnt > (PTR_W+1)'(XMIT_BUSY_LEVEL);
		nxt_rs = nxt_ovr || loss_ff == '1;
	end
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			at_os_ff <= '0;
			at_left_ff <= '0;
			at_sh_ff <= '1;
			out_ff <= LINE_IDLE;
			ovr_ff <= 1'b0;
			xs_ff <= STATUS_RESET;
			rs_ff <= STATUS_RESET;
		end else begin
			at_os_ff <= nxt_at_os;
			at_left_ff <= nxt_at_left;
			at_sh_ff <= nxt_at_sh;
			out_ff <= nxt_out;
			ovr_ff <= nxt_ovr;
			xs_ff <= nxt_xs;
			rs_ff <= nxt_rs;
		end
	end
	assign ASYNC_OUT = out_ff;
	assign XMIT_FIFO_STATUS = xs_ff;
	assign RECV_FIFO_STATUS = rs_ff;
endmodule : asc_converter

/* File: inc/asc_pkg.sv */
package asc_pkg;
	// =====================================================
	// Widths and depths
	localparam int DATA_W = 9;
	localparam int FIFO_DEPTH = 4;
	localparam int PTR_W = 2;
	localparam int CNT_W = 3;
	localparam int XMIT_BUSY_LEVEL = 2;
	localparam int SYNC_WORD_BITS = 8;
	localparam int OVERSAMPLE = 16;
	localparam int OS_MID = 7;
	localparam int OS_LAST = 15;
	// =====================================================
	// Rate generator, reference 4.096 MHz, divide to 16x rate
	localparam int DIV_W = 10;
	localparam logic [DIV_W-1:0] DIV_300 = 10'h355;
	localparam logic [DIV_W-1:0] DIV_600 = 10'h1aa;
	localparam logic [DIV_W-1:0] DIV_1200 = 10'h0d5;
	localparam logic [DIV_W-1:0] DIV_2400 = 10'h06a;
	localparam logic [DIV_W-1:0] DIV_4800 = 10'h035;
	localparam logic [DIV_W-1:0] DIV_9600 = 10'h01a;
	localparam logic [DIV_W-1:0] DIV_38400 = 10'h006;
	// =====================================================
	// Sync channel modes and loss-of-sync watch
	localparam logic MODE_CONT = 1'b0;
	localparam logic MODE_BURST = 1'b1;
	localparam logic [7:0] SYNC_FLAG_WORD = 8'h7e;
	localparam int SYNC_LOSS_WORDS = 16;
	localparam int SYNC_LOSS_W = 5;
	// =====================================================
	// Reset values
	localparam logic LINE_IDLE = 1'b1;
	localparam logic STATUS_RESET = 1'b1;
endpackage : asc_pkg

/* File: inc/asc_sync_if.sv */
interface asc_sync_if;
	// Data clock sampled synchronously, both modes
	logic sync_bit_clock;
	logic clock_mode_select;
	logic sync_out_enable;
	logic sync_in_enable;
	logic sync_channel_out;
	logic sync_channel_in;
	// Converter end: drives the data line from itself
	modport conv (
		input sync_bit_clock,
		input clock_mode_select,
		input sync_out_enable,
		input sync_in_enable,
		input sync_channel_in,
		output sync_channel_out
	);
	// Loop end: makes the clock and the enables
	modport loop (
		output sync_bit_clock,
		output clock_mode_select,
		output sync_out_enable,
		output sync_in_enable,
		output sync_channel_in,
		input sync_channel_out
	);
endinterface : asc_sync_if

/* File: logic/asc_loop_end.sv */
module asc_loop_end #(
	parameter int HALF_DIV = 4
) (
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic RST,
	// User side
	input wire logic MODE,
	input wire logic LINE_IN,
	output logic LINE_OUT,
	// Synchronous channel
	asc_sync_if.loop SYNC
);
	import asc_pkg::*;
	// Eight-bit divider and edge detection need at least two cycles
	if (HALF_DIV < 2 || HALF_DIV > 255) begin : gen_bad_div
		$error("asc_loop_end: HALF_DIV out of range");
	end
	// =====================================================
	// Data clock from divider, enables high for eight bits in burst mode
	logic [7:0] div_ff, nxt_div;
	logic dc_ff, nxt_dc;
	logic [3:0] bit_ff, nxt_bit;
	logic en_ff, nxt_en;
	logic din_ff, nxt_din;
	logic dout_ff, nxt_dout;
	logic mode_ff, nxt_mode;
	always_comb begin
		nxt_div = div_ff + 1'b1;
		nxt_dc = dc_ff;
		nxt_bit = bit_ff;
		// Enables stand high as soon as continuous mode is chosen
		nxt_en = (MODE == MODE_CONT) ? 1'b1 : en_ff;
		nxt_din = din_ff;
		nxt_dout = dout_ff;
		nxt_mode = MODE;
		if (div_ff == 8'(HALF_DIV - 1)) begin
			nxt_div = '0;
			nxt_dc = !dc_ff;
			if (dc_ff) begin
				// Falling edge next: converter samples, we present
				nxt_din = LINE_IN;
				nxt_dout = SYNC.sync_channel_out;
				nxt_bit = (bit_ff == 4'h9) ? '0 : bit_ff + 1'b1;
				nxt_en = (MODE == MODE_CONT) || (bit_ff < 4'h7) || (bit_ff == 4'h9);
			end
		end
	end
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			div_ff <= '0;
			dc_ff <= 1'b1;
			bit_ff <= '0;
			en_ff <= 1'b1;
			din_ff <= LINE_IDLE;
			dout_ff <= LINE_IDLE;
			mode_ff <= MODE_CONT;
		end else begin
			div_ff <= nxt_div;
			dc_ff <= nxt_dc;
			bit_ff <= nxt_bit;
			en_ff <= nxt_en;
			din_ff <= nxt_din;
			dout_ff <= nxt_dout;
			mode_ff <= nxt_mode;
		end
	end
	assign SYNC.sync_bit_clock = dc_ff;
	assign SYNC.clock_mode_select = mode_ff;
	assign SYNC.sync_out_enable = en_ff;
	assign SYNC.sync_in_enable = en_ff;
	assign SYNC.sync_channel_in = din_ff;
	assign LINE_OUT = dout_ff;
endmodule : asc_loop_end

/* File: tb/asc_sync_props.sv */
module asc_sync_props #(
	parameter int HALF_DIV = 4
) (
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic RST,
	// Synchronous channel
	input wire logic sync_bit_clock,
	input wire logic clock_mode_select,
	input wire logic sync_out_enable,
	input wire logic sync_in_enable,
	input wire logic sync_channel_out,
	input wire logic sync_channel_in
);
	timeunit 1ns;
	timeprecision 1ns;
	// =====================================================
	// History of clock, enable, mode and line
	logic [4:0] dc_ff, nxt_dc, en_ff, nxt_en;
	logic [3:0] mode_ff, nxt_mode, shift_ff, nxt_shift;
	logic [9:0] half_ff, nxt_half;
	logic seen_ff, nxt_seen, out_ff, nxt_out, tog;
	// Half count restarts at each toggle; a mode change voids it
	always_comb begin
		tog = sync_bit_clock != dc_ff[0];
		nxt_dc = {dc_ff[3:0], sync_bit_clock};
		nxt_en = {en_ff[3:0], sync_out_enable};
		nxt_mode = {mode_ff[2:0], clock_mode_select};
		nxt_out = sync_channel_out;
		nxt_half = tog ? 10'h001 : half_ff + 10'h001;
		nxt_seen = !clock_mode_select && (seen_ff || tog);
		nxt_shift = shift_ff + 4'(sync_channel_out != out_ff);
		// Count restarts per enable period; continuous mode never counts
		if (!clock_mode_select || (sync_out_enable && !en_ff[0])) begin
			nxt_shift = 4'h0;
		end
	end
	// Registers only
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			dc_ff <= 5'h1f;
			en_ff <= 5'h1f;
			mode_ff <= 4'h0;
			out_ff <= 1'b1;
			half_ff <= 10'h000;
			seen_ff <= 1'b0;
			shift_ff <= 4'h0;
		end else begin
			dc_ff <= nxt_dc;
			en_ff <= nxt_en;
			mode_ff <= nxt_mode;
			out_ff <= nxt_out;
			half_ff <= nxt_half;
			seen_ff <= nxt_seen;
			shift_ff <= nxt_shift;
		end
	end
	// =====================================================
	// Properties
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (RST);
	chk_reset_rest: assert property (disable iff (1'b0) RST && $past(RST) |-> sync_channel_out
		&& sync_bit_clock && sync_out_enable && sync_in_enable && !clock_mode_select)
		else $error("channel not at rest in reset");
	chk_cont_enables: assert property (mode_ff == 4'h0 && !clock_mode_select
		|-> sync_out_enable && sync_in_enable) else $error("enables low in continuous mode");
	chk_cont_fall: assert property (mode_ff == 4'h0 && $changed(sync_channel_out)
		|-> |(dc_ff[4:1] & ~dc_ff[3:0])) else $error("continuous shift not after fall");
	chk_burst_rise: assert property (mode_ff == 4'hf && $changed(sync_channel_out)
		|-> |(~dc_ff[4:1] & dc_ff[3:0])) else $error("burst shift not after rise");
	chk_burst_gate: assert property (mode_ff == 4'hf && $changed(sync_channel_out)
		|-> |en_ff) else $error("burst shift while enable low");
	chk_burst_count: assert property (clock_mode_select |-> shift_ff <= 4'h8)
		else $error("more than eight bits in one enable period");
	chk_release_idle: assert property ($fell(RST) |-> sync_channel_out
		##1 sync_channel_out) else $error("line not idle after reset");
	chk_half_period: assert property (mode_ff == 4'h0 && seen_ff && tog
		|-> half_ff == 10'(HALF_DIV)) else $error("data clock half period wrong");
	// Main scenarios
	cov_cont_word: cover property (mode_ff == 4'h0 && $fell(sync_channel_out));
	cov_burst_shift: cover property (mode_ff == 4'hf && $changed(sync_channel_out));
	cov_in_word: cover property ($fell(sync_channel_in));
endmodule : asc_sync_props

/* File: tb/async_sync_data_converter_test.sv */
module async_sync_data_converter_test;
	timeunit 1ns;
	timeprecision 1ns;
	import asc_pkg::*;
	// =====================================================
	// Slow data clock so the transmit FIFO can be outrun
	localparam int HD = 100;
	localparam int BC0 = 96;
	logic sys_clk, rst, async_in, ref_clk, wls, mode, line_in;
	logic async_out, xmit_st, recv_st, line_out;
	logic [2:0] rate_sel;
	int ref_cnt, bad_count, checked;
	asc_sync_if sif ();
	asc_converter asc_converter_i (.SYS_CLK(sys_clk), .RST(rst), .ASYNC_IN(async_in),
		.ASYNC_OUT(async_out), .RATE_REF_CLOCK(ref_clk), .RATE_SELECT_0(rate_sel[0]),
		.RATE_SELECT_1(rate_sel[1]), .RATE_SELECT_2(rate_sel[2]), .WORD_LENGTH_SELECT(wls),
		.XMIT_FIFO_STATUS(xmit_st), .RECV_FIFO_STATUS(recv_st), .SYNC(sif.conv));
	asc_loop_end #(.HALF_DIV(HD)) asc_loop_end_i (.SYS_CLK(sys_clk), .RST(rst),
		.MODE(mode), .LINE_IN(line_in), .LINE_OUT(line_out), .SYNC(sif.loop));
	asc_sync_props #(.HALF_DIV(HD)) asc_sync_props_i (.SYS_CLK(sys_clk), .RST(rst),
		.sync_bit_clock(sif.sync_bit_clock), .clock_mode_select(sif.clock_mode_select),
		.sync_out_enable(sif.sync_out_enable), .sync_in_enable(sif.sync_in_enable),
		.sync_channel_out(sif.sync_channel_out), .sync_channel_in(sif.sync_channel_in));
	// =====================================================
	// Clocks: reference period is six system cycles, rates scale with it
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		ref_cnt <= (ref_cnt == 2) ? 0 : ref_cnt + 1;
		if (ref_cnt == 2) ref_clk <= ~ref_clk;
	end
	// =====================================================
	// Shared tasks
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : cyc
	task automatic check(input string name, input logic [8:0] seen, input logic [8:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic test_done();
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : test_done
	// Framed character, start low, data LSB first, stop high
	task automatic send_async(input logic [8:0] d, input int n, input int bc);
		logic [10:0] f;
		f = {1'b1, d, 1'b0} | (11'h001 << (n + 1));
		for (int i = 0; i < n + 2; i++) begin
			async_in <= f[i];
			cyc(bc);
		end
	endtask : send_async
	// Burst mode: sample at the fall after an enabled rise
	task automatic sync_edge();
		logic e;
		e = 1'b0;
		if (mode) begin
			while (!e) begin
				@(posedge sif.sync_bit_clock);
				e = sif.sync_out_enable === 1'b1;
				@(negedge sif.sync_bit_clock);
			end
		end else begin
			@(posedge sif.sync_bit_clock);
		end
	endtask : sync_edge
	task automatic get_sync(input string name, input logic [8:0] exp, input int n);
		logic [8:0] w;
		int k;
		w = 9'h000;
		k = 0;
		while (sif.sync_channel_out !== 1'b0 && k < 60) begin
			sync_edge();
			k++;
		end
		// Loop end hands the start marker on at the next fall
		if (!mode) begin
			@(negedge sif.sync_bit_clock);
			cyc(1);
			check({name, " line"}, 9'(line_out), 9'h000);
		end
		for (int i = 0; i < n; i++) begin
			sync_edge();
			w[i] = sif.sync_channel_out;
		end
		check(name, w, exp);
	endtask : get_sync
	// Drive the loop end one bit per data clock, idle high after
	task automatic send_sync(input logic [15:0] b, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge sif.sync_bit_clock);
			line_in <= b[i];
		end
		@(posedge sif.sync_bit_clock);
		line_in <= 1'b1;
	endtask : send_sync
	// Expects data bit 0 high, so the start bit length is one bit time
	task automatic get_async(input string name, input logic [8:0] exp, input int bc);
		logic [8:0] w;
		int k;
		w = 9'h000;
		k = 0;
		while (async_out !== 1'b0 && k < 9000) begin
			cyc(1);
			k++;
		end
		k = 0;
		while (async_out === 1'b0 && k < 2000) begin
			cyc(1);
			k++;
		end
		check({name, " bit time"}, 9'(k > bc - 8 && k < bc + 8), 9'h001);
		cyc(bc / 2);
		for (int i = 0; i < 8; i++) begin
			w[i] = async_out;
			cyc(bc);
		end
		check(name, w, exp);
		check({name, " stop"}, 9'(async_out), 9'h001);
	endtask : get_async
	// =====================================================
	// Scenarios
	task automatic t_a2s(input string name, input logic [8:0] d, input int n);
		wls <= n == 9;
		cyc(2);
		fork
			send_async(d, n, BC0);
			get_sync(name, d, n);
		join
		$display("test %s done", name);
	endtask : t_a2s
	task automatic t_s2a(input string name, input logic [2:0] code, input int bc);
		rate_sel <= code;
		wls <= 1'b0;
		cyc(2);
		fork
			send_sync({7'h7f, 8'h6b, 1'b0}, 16);
			get_async(name, 9'h06b, bc);
		join
		rate_sel <= 3'h0;
		$display("test %s done", name);
	endtask : t_s2a
	task automatic t_fifo();
		for (int i = 0; i < 6; i++) begin
			send_async(9'(8'h31 + i), 8, BC0);
		end
		check("xmit status full", 9'(xmit_st), 9'h001);
		cyc(14000);
		check("xmit status drained", 9'(xmit_st), 9'h000);
		$display("test fifo done");
	endtask : t_fifo
	task automatic t_false();
		logic low;
		low = 1'b0;
		async_in <= 1'b0;
		cyc(18);
		async_in <= 1'b1;
		repeat (20) begin
			@(posedge sif.sync_bit_clock);
			low = low | (sif.sync_channel_out !== 1'b1);
		end
		check("false start", 9'(low), 9'h000);
		$display("test false start done");
	endtask : t_false
	// Slow output rate lets flag-carrying words overrun the receive FIFO
	task automatic t_over();
		rate_sel <= 3'h1;
		repeat (6) send_sync({7'h7f, 8'h7e, 1'b0}, 9);
		cyc(4);
		check("recv status overwrite", 9'(recv_st), 9'h001);
		rate_sel <= 3'h0;
		cyc(5000);
		check("recv status drained", 9'(recv_st), 9'h000);
		$display("test overwrite done");
	endtask : t_over
	task automatic t_loss();
		send_sync(16'h7e7e, 16);
		cyc(4 * HD);
		check("recv status flag", 9'(recv_st), 9'h000);
		cyc(70 * HD);
		check("recv status lost", 9'(recv_st), 9'h001);
		$display("test sync loss done");
	endtask : t_loss
	// =====================================================
	// Watchdog
	initial begin
		cyc(95000);
		bad_count++;
		$display("MISMATCH watchdog expected done seen timeout");
		test_done();
	end
	// Main sequence
	initial begin
		rst = 1'b1;
		async_in = 1'b1;
		ref_clk = 1'b0;
		ref_cnt = 0;
		wls = 1'b0;
		mode = 1'b0;
		line_in = 1'b1;
		rate_sel = 3'h0;
		bad_count = 0;
		checked = 0;
		cyc(3);
		check("xmit status reset", 9'(xmit_st), 9'h001);
		check("recv status reset", 9'(recv_st), 9'h001);
		check("async out reset", 9'(async_out), 9'h001);
		rst <= 1'b0;
		cyc(2);
		check("xmit status idle", 9'(xmit_st), 9'h000);
		t_a2s("eight bit", 9'h0a5, 8);
		t_a2s("nine bit", 9'h15a, 9);
		mode <= 1'b1;
		cyc(10);
		t_a2s("burst", 9'h0c3, 8);
		mode <= 1'b0;
		cyc(10);
		t_s2a("rate ref", 3'h0, BC0);
		t_s2a("rate top", 3'h7, BC0 * int'(DIV_38400));
		t_fifo();
		t_false();
		t_over();
		t_loss();
		test_done();
	end
endmodule : async_sync_data_converter_test
